// File: src/scs_pkg.sv
// Package: register map, field layout, reset values and loop constants of the clock select block
package scs_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SYS_CFG_OFS = 8'h00;
  localparam logic [7:0] PLL_CFG_OFS = 8'h04;
  localparam logic [7:0] PRESC_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int SRC_LSB = 0;
  localparam int REFSEL_BIT = 2;
  localparam int BYP_BIT = 0;
  localparam int BAND_LSB = 1;
  localparam int PLL_INPUT_DIVIDER_LSB = 4;
  localparam int PLL_INPUT_DIVIDER_W = 4;
  localparam int PLL_FEEDBACK_MULTIPLIER_LSB = 8;
  localparam int PLL_FEEDBACK_MULTIPLIER_W = 7;
  localparam int K2_LSB = 16;
  localparam int K2_W = 7;
  localparam int K1_W = 10;
  // ----------------------------------------------------------------
  // Source select codes and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_WAKEUP = 2'h0,
    SRC_RSVD = 2'h1,
    SRC_PLL = 2'h2,
    SRC_DIRECT = 2'h3
  } scs_src_e;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic BYP_RST = 1'b1;
  localparam logic [1:0] BAND_RST = 2'h0;
  localparam logic [PLL_INPUT_DIVIDER_W-1:0] PLL_INPUT_DIVIDER_RST = 4'h0;
  localparam logic [PLL_FEEDBACK_MULTIPLIER_W-1:0] PLL_FEEDBACK_MULTIPLIER_RST = 7'h03;
  localparam logic [K2_W-1:0] K2_RST = 7'h01;
  localparam logic [K1_W-1:0] K1_RST = 10'h000;
  // ----------------------------------------------------------------
  // Digital oscillator: accumulator width and per-band increment limits
  // ----------------------------------------------------------------
  localparam int ACC_W = 16;
  localparam logic [ACC_W-1:0] BAND0_MIN = 16'h0400;
  localparam logic [ACC_W-1:0] BAND0_MAX = 16'h4000;
  localparam logic [ACC_W-1:0] BAND1_MIN = 16'h2000;
  localparam logic [ACC_W-1:0] BAND1_MAX = 16'h7000;
  localparam int VCNT_W = 9;
  // ----------------------------------------------------------------
  // Bus constants
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage : scs_pkg

// File: src/scs_div_if.sv
// Interface between the clock select core and its edge-counting dividers
`timescale 1ns/100ps
`default_nettype none
interface scs_div_if #(parameter int W = 10);
  logic src_level;
  logic [W-1:0] ratio_m1;
  logic out_level;
  modport ctl (output src_level, output ratio_m1, input out_level);
  modport div (input src_level, input ratio_m1, output out_level);
endinterface : scs_div_if
`default_nettype wire

// File: src/scs_divider.sv
// Glitch-free divide-by-K of a sampled clock level, ratio reloaded at period end
`timescale 1ns/100ps
`default_nettype none
module scs_divider #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Divider port
  scs_div_if.div d
);
  if (W < 1 || W > 16) begin : g_chk
    $error("scs_divider: W out of range");
  end
  logic [W-1:0] cnt_q, cnt_d;
  logic [W-1:0] ratio_q, ratio_d;
  logic prev_q, prev_d;
  logic out_q, out_d;
  logic rise;
  assign d.out_level = out_q;
  always_comb begin
    rise = d.src_level & ~prev_q;
    prev_d = d.src_level;
    cnt_d = cnt_q;
    ratio_d = ratio_q;
    out_d = out_q;
    if (ratio_q == '0) begin
      // Divide by one follows the source, duty cycle and all
      out_d = d.src_level;
      ratio_d = d.ratio_m1;
      cnt_d = '0;
    end else if (rise) begin
      if (cnt_q == ratio_q) begin
        // New ratio only at a period boundary, so no runt period appears
        cnt_d = '0;
        ratio_d = d.ratio_m1;
        out_d = 1'b1;
      end else begin
        cnt_d = W'(cnt_q + 1'b1);
        out_d = ({1'b0, cnt_d} < ({1'b0, ratio_q} + 1'b1) >> 1);
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      ratio_q <= '0;
      prev_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ratio_q <= ratio_d;
      prev_q <= prev_d;
      out_q <= out_d;
    end
  end
endmodule : scs_divider
`default_nettype wire

// File: src/scs_clock_select.sv
// Top: system clock source select, prescaler and digital PLL with AHB-Lite registers
// Functional notes
// - Source code 10 with bypass clear runs the PLL and takes its clock.
// - PLL output equals input times N over P times K2, fields plus one.
// - PLL reference selects oscillator pin or on-chip clock source.
// - With code 10 and bypass clear, the system clock is the VCO clock divided by K2.
// - PLL frequency moves in one-LSB steps while tracking, but a band change leaving it outside the new band moves it to the nearer band limit at once.
// - Band field 00 picks lower VCO band, 01 the higher band.
// - Source code 00 runs the system clock from the wakeup clock.
// - Source code 11 passes the direct clock input straight through.
// - Code 10 with bypass set divides the selected PLL reference clock by K1, up to 1024.
`timescale 1ns/100ps
`default_nettype none
module scs_clock_select (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Clock source levels, sampled synchronously
  input wire logic i_oscillator_input_pin,
  input wire logic i_onchip_clock,
  input wire logic i_wakeup_clock,
  input wire logic i_direct_clock_input_pin,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Generated clock and state
  output logic o_sys_clk,
  output logic o_pll_locked
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [scs_pkg::ACC_W-1:0] band_min(input logic [1:0] band);
    band_min = band[0] ? scs_pkg::BAND1_MIN : scs_pkg::BAND0_MIN;
  endfunction : band_min
  function automatic logic [scs_pkg::ACC_W-1:0] band_max(input logic [1:0] band);
    band_max = band[0] ? scs_pkg::BAND1_MAX : scs_pkg::BAND0_MAX;
  endfunction : band_max
  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [1:0] src_q, src_d;
  logic refsel_q, refsel_d;
  logic byp_q, byp_d;
  logic [1:0] band_q, band_d;
  logic [scs_pkg::PLL_INPUT_DIVIDER_W-1:0] pll_input_divider_q, pll_input_divider_d;
  logic [scs_pkg::PLL_FEEDBACK_MULTIPLIER_W-1:0] pll_feedback_multiplier_q, pll_feedback_multiplier_d;
  logic [scs_pkg::K2_W-1:0] k2_q, k2_d;
  logic [scs_pkg::K1_W-1:0] k1_q, k1_d;
  logic wpend_q, wpend_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] act_q, act_d;
  logic locked_q, locked_d;
  logic [scs_pkg::ACC_W-1:0] inc_q, inc_d;
  logic aphase;
  always_comb begin
    src_d = src_q;
    refsel_d = refsel_q;
    byp_d = byp_q;
    band_d = band_q;
    pll_input_divider_d = pll_input_divider_q;
    pll_feedback_multiplier_d = pll_feedback_multiplier_q;
    k2_d = k2_q;
    k1_d = k1_q;
    rdata_d = rdata_q;
    aphase = i_hsel && i_hready && (i_htrans == scs_pkg::HTRANS_NONSEQ);
    wpend_d = aphase && i_hwrite;
    waddr_d = aphase ? i_haddr[7:0] : waddr_q;
    if (wpend_q) begin
      unique case (waddr_q)
        scs_pkg::SYS_CFG_OFS: begin
          src_d = i_hwdata[scs_pkg::SRC_LSB +: 2];
          refsel_d = i_hwdata[scs_pkg::REFSEL_BIT];
        end
        scs_pkg::PLL_CFG_OFS: begin
          byp_d = i_hwdata[scs_pkg::BYP_BIT];
          band_d = i_hwdata[scs_pkg::BAND_LSB +: 2];
          pll_input_divider_d = i_hwdata[scs_pkg::PLL_INPUT_DIVIDER_LSB +: scs_pkg::PLL_INPUT_DIVIDER_W];
          pll_feedback_multiplier_d = i_hwdata[scs_pkg::PLL_FEEDBACK_MULTIPLIER_LSB +: scs_pkg::PLL_FEEDBACK_MULTIPLIER_W];
          k2_d = i_hwdata[scs_pkg::K2_LSB +: scs_pkg::K2_W];
        end
        scs_pkg::PRESC_OFS: k1_d = i_hwdata[scs_pkg::K1_W-1:0];
        default: ;
      endcase
    end
    if (aphase && !i_hwrite) begin
      rdata_d = '0;
      unique case (i_haddr[7:0])
        scs_pkg::SYS_CFG_OFS: begin
          rdata_d[scs_pkg::SRC_LSB +: 2] = src_q;
          rdata_d[scs_pkg::REFSEL_BIT] = refsel_q;
        end
        scs_pkg::PLL_CFG_OFS: begin
          rdata_d[scs_pkg::BYP_BIT] = byp_q;
          rdata_d[scs_pkg::BAND_LSB +: 2] = band_q;
          rdata_d[scs_pkg::PLL_INPUT_DIVIDER_LSB +: scs_pkg::PLL_INPUT_DIVIDER_W] = pll_input_divider_q;
          rdata_d[scs_pkg::PLL_FEEDBACK_MULTIPLIER_LSB +: scs_pkg::PLL_FEEDBACK_MULTIPLIER_W] = pll_feedback_multiplier_q;
          rdata_d[scs_pkg::K2_LSB +: scs_pkg::K2_W] = k2_q;
        end
        scs_pkg::PRESC_OFS: rdata_d[scs_pkg::K1_W-1:0] = k1_q;
        // Status: active source, lock, oscillator increment
        scs_pkg::STATUS_OFS: rdata_d = {act_q, 13'h0000, locked_q, inc_q};
        default: rdata_d = '0;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_q <= scs_pkg::SRC_RST;
      refsel_q <= 1'b0;
      byp_q <= scs_pkg::BYP_RST;
      band_q <= scs_pkg::BAND_RST;
      pll_input_divider_q <= scs_pkg::PLL_INPUT_DIVIDER_RST;
      pll_feedback_multiplier_q <= scs_pkg::PLL_FEEDBACK_MULTIPLIER_RST;
      k2_q <= scs_pkg::K2_RST;
      k1_q <= scs_pkg::K1_RST;
      wpend_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= scs_pkg::RDATA_RST;
    end else begin
      src_q <= src_d;
      refsel_q <= refsel_d;
      byp_q <= byp_d;
      band_q <= band_d;
      pll_input_divider_q <= pll_input_divider_d;
      pll_feedback_multiplier_q <= pll_feedback_multiplier_d;
      k2_q <= k2_d;
      k1_q <= k1_d;
      wpend_q <= wpend_d;
      waddr_q <= waddr_d;
      rdata_q <= rdata_d;
    end
  end
  assign o_hrdata = rdata_q;
  // Zero wait states and OKAY always: both held as constant flops
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Digital PLL: oscillator, feedback count and gradual tracking
  // ----------------------------------------------------------------
  logic ref_level;
  logic pll_en;
  logic [scs_pkg::ACC_W-1:0] acc_q, acc_d;
  logic ref_prev_q, ref_prev_d;
  logic vco_prev_q, vco_prev_d;
  logic [scs_pkg::PLL_INPUT_DIVIDER_W-1:0] rcnt_q, rcnt_d;
  logic [scs_pkg::VCNT_W-1:0] vcnt_q, vcnt_d;
  assign ref_level = refsel_q ? i_onchip_clock : i_oscillator_input_pin;
  assign pll_en = (src_q == scs_pkg::SRC_PLL) && !byp_q;
  always_comb begin
    acc_d = acc_q;
    inc_d = inc_q;
    rcnt_d = rcnt_q;
    vcnt_d = vcnt_q;
    locked_d = locked_q;
    ref_prev_d = ref_level;
    vco_prev_d = acc_q[scs_pkg::ACC_W-1];
    if (!pll_en) begin
      // Powered down: restart from the bottom of the selected band
      acc_d = '0;
      inc_d = band_min(band_q);
      rcnt_d = '0;
      vcnt_d = '0;
      locked_d = 1'b0;
    end else begin
      acc_d = scs_pkg::ACC_W'(acc_q + inc_q);
      if (acc_q[scs_pkg::ACC_W-1] && !vco_prev_q && vcnt_q != '1) begin
        vcnt_d = scs_pkg::VCNT_W'(vcnt_q + 1'b1);
      end
      if (ref_level && !ref_prev_q) begin
        if (rcnt_q == pll_input_divider_q) begin
          // Window of P+1 reference periods must hold N+1 oscillator periods
          rcnt_d = '0;
          vcnt_d = '0;
          locked_d = (vcnt_q == {2'b00, pll_feedback_multiplier_q} + 1'b1);
          // One LSB per window keeps the frequency from jumping
          if (vcnt_q < {2'b00, pll_feedback_multiplier_q} + 1'b1 && inc_q < band_max(band_q)) begin
            inc_d = scs_pkg::ACC_W'(inc_q + 1'b1);
          end else if (vcnt_q > {2'b00, pll_feedback_multiplier_q} + 1'b1 && inc_q > band_min(band_q)) begin
            inc_d = scs_pkg::ACC_W'(inc_q - 1'b1);
          end
        end else begin
          rcnt_d = scs_pkg::PLL_INPUT_DIVIDER_W'(rcnt_q + 1'b1);
        end
      end
      // A band change takes hold at once, not at the next slow reference window
      if (inc_q > band_max(band_q)) begin
        inc_d = band_max(band_q);
      end else if (inc_q < band_min(band_q)) begin
        inc_d = band_min(band_q);
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_q <= '0;
      inc_q <= scs_pkg::BAND0_MIN;
      rcnt_q <= '0;
      vcnt_q <= '0;
      locked_q <= 1'b0;
      ref_prev_q <= 1'b0;
      vco_prev_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      inc_q <= inc_d;
      rcnt_q <= rcnt_d;
      vcnt_q <= vcnt_d;
      locked_q <= locked_d;
      ref_prev_q <= ref_prev_d;
      vco_prev_q <= vco_prev_d;
    end
  end
  // ----------------------------------------------------------------
  // Output divider K2 and prescaler K1
  // ----------------------------------------------------------------
  scs_div_if #(.W(scs_pkg::K2_W)) k2_if ();
  scs_div_if #(.W(scs_pkg::K1_W)) k1_if ();
  assign k2_if.src_level = acc_q[scs_pkg::ACC_W-1];
  assign k2_if.ratio_m1 = k2_q;
  assign k1_if.src_level = ref_level;
  assign k1_if.ratio_m1 = k1_q;
  scs_divider #(.W(scs_pkg::K2_W)) u_k2_div (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .d(k2_if.div)
  );
  scs_divider #(.W(scs_pkg::K1_W)) u_k1_div (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .d(k1_if.div)
  );
  // ----------------------------------------------------------------
  // Glitch-free source switch
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_PRESC = 3'h4;
  logic [4:0] cand;
  logic [2:0] req;
  logic [2:0] cur;
  logic [2:0] nxt;
  logic act_byp_q, act_byp_d;
  logic clk_d;
  always_comb begin
    cand[scs_pkg::SRC_WAKEUP] = i_wakeup_clock;
    cand[scs_pkg::SRC_RSVD] = i_wakeup_clock;
    cand[scs_pkg::SRC_PLL] = k2_if.out_level;
    cand[scs_pkg::SRC_DIRECT] = i_direct_clock_input_pin;
    cand[SEL_PRESC] = k1_if.out_level;
    // Prescaler is a selection of its own, so flipping bypass also waits for low levels
    req = (src_q == scs_pkg::SRC_PLL && byp_q) ? SEL_PRESC : {1'b0, src_q};
    cur = act_byp_q ? SEL_PRESC : {1'b0, act_q};
    nxt = cur;
    // Hand over only while old and new clocks are both low: no runt pulse
    if (req != cur && !o_sys_clk && !cand[req]) begin
      nxt = req;
    end
    act_byp_d = (nxt == SEL_PRESC);
    act_d = act_byp_d ? scs_pkg::SRC_PLL : nxt[1:0];
    clk_d = cand[nxt];
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      act_q <= scs_pkg::SRC_RST;
      act_byp_q <= 1'b0;
      o_sys_clk <= 1'b0;
      o_pll_locked <= 1'b0;
    end else begin
      act_q <= act_d;
      act_byp_q <= act_byp_d;
      o_sys_clk <= clk_d;
      o_pll_locked <= locked_q;
    end
  end
endmodule : scs_clock_select
`default_nettype wire

// File: dv/scs_clock_select_asserts.sv
// Checker: port-level properties of the clock select block
`timescale 1ns/100ps
`default_nettype none
module scs_clock_select_asserts (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Clock sources
  input wire logic i_oscillator_input_pin,
  input wire logic i_onchip_clock,
  input wire logic i_wakeup_clock,
  input wire logic i_direct_clock_input_pin,
  // Bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // Clock output
  input wire logic o_sys_clk,
  input wire logic o_pll_locked
);
  // --------------------------------
  // Shadow of the written setup
  // --------------------------------
  logic take, rd, band_hi, wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [31:0] sys_q, sys_d, pll_q, pll_d;
  logic [6:0] quiet_q, quiet_d;
  assign take = i_hsel && i_hready && i_htrans == scs_pkg::HTRANS_NONSEQ;
  assign rd = take && !i_hwrite;
  assign band_hi = pll_q[1];
  always_comb begin
    wr_d = take && i_hwrite;
    wa_d = take ? i_haddr[7:0] : wa_q;
    sys_d = sys_q;
    pll_d = pll_q;
    quiet_d = wr_q ? 7'h00 : quiet_q + {6'h00, quiet_q != 7'h7F};
    if (wr_q && wa_q == scs_pkg::SYS_CFG_OFS) begin
      sys_d = i_hwdata & 32'h0000_0007;
    end
    if (wr_q && wa_q == scs_pkg::PLL_CFG_OFS) begin
      pll_d = i_hwdata & 32'h007F_7FF7;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      sys_q <= 32'h0000_0000;
      pll_q <= 32'h0001_0301;
      quiet_q <= 7'h00;
    end else begin
      wr_q <= wr_d;
      wa_q <= wa_d;
      sys_q <= sys_d;
      pll_q <= pll_d;
      quiet_q <= quiet_d;
    end
  end
  // --------------------------------
  // Properties
  // --------------------------------
  // Source following is only judged after a quiet spell, since a switch waits for low levels
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_bus_okay;
    o_hreadyout && !o_hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("slave stalled or gave an error");
  property p_unmapped_zero;
    rd && i_haddr[7:0] > scs_pkg::STATUS_OFS |=> o_hrdata == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_sys_readback;
    rd && i_haddr[7:0] == scs_pkg::SYS_CFG_OFS |=> o_hrdata == $past(sys_q);
  endproperty
  a_sys_readback: assert property (p_sys_readback) else $error("source setup readback wrong");
  property p_pll_readback;
    rd && i_haddr[7:0] == scs_pkg::PLL_CFG_OFS |=> o_hrdata == $past(pll_q);
  endproperty
  a_pll_readback: assert property (p_pll_readback) else $error("loop setup readback wrong");
  property p_wakeup_follow;
    sys_q[1:0] == 2'h0 && quiet_q == 7'h7F |-> o_sys_clk == $past(i_wakeup_clock);
  endproperty
  a_wakeup_follow: assert property (p_wakeup_follow) else $error("wakeup not followed");
  property p_direct_follow;
    sys_q[1:0] == 2'h3 && quiet_q == 7'h7F |-> o_sys_clk == $past(i_direct_clock_input_pin);
  endproperty
  a_direct_follow: assert property (p_direct_follow) else $error("direct not followed");
  property p_no_runt;
    o_sys_clk != $past(o_sys_clk) |=> o_sys_clk == $past(o_sys_clk);
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("one cycle pulse on clock");
  property p_band_range;
    rd && i_haddr[7:0] == scs_pkg::STATUS_OFS && quiet_q > 7'h08 |=> $past(band_hi) ?
      o_hrdata[15:0] inside {[scs_pkg::BAND1_MIN:scs_pkg::BAND1_MAX]} :
      o_hrdata[15:0] inside {[scs_pkg::BAND0_MIN:scs_pkg::BAND0_MAX]};
  endproperty
  a_band_range: assert property (p_band_range) else $error("step outside band");
  c_direct: cover property (sys_q[1:0] == 2'h3 && quiet_q == 7'h7F);
  c_locked: cover property (o_pll_locked && !pll_q[0]);
  c_prescale: cover property (sys_q[1:0] == 2'h2 && pll_q[0] && o_sys_clk);
endmodule : scs_clock_select_asserts
bind scs_clock_select scs_clock_select_asserts i_scs_clock_select_asserts (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_oscillator_input_pin(i_oscillator_input_pin),
  .i_onchip_clock(i_onchip_clock), .i_wakeup_clock(i_wakeup_clock),
  .i_direct_clock_input_pin(i_direct_clock_input_pin), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_sys_clk(o_sys_clk), .o_pll_locked(o_pll_locked)
);
`default_nettype wire

// File: dv/tb.sv
// Testbench: registers, clock sources, prescaler and loop of the clock select block
`timescale 1ns/100ps
`default_nettype none
module tb;
  // --------------------------------
  // Signals and design
  // --------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] src = 4'h0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hrdy, hresp, sclk, locked;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  // Half periods in cycles: oscillator, on-chip, wakeup, direct
  int hp [4] = '{4, 5, 6, 3};
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      if (cyc % hp[i] == hp[i] - 1) begin
        src[i] <= ~src[i];
      end
    end
  end
  scs_clock_select i_scs_clock_select (
    .i_sys_clk(clk), .i_rstn(rstn), .i_oscillator_input_pin(src[0]),
    .i_onchip_clock(src[1]), .i_wakeup_clock(src[2]), .i_direct_clock_input_pin(src[3]),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_sys_clk(sclk), .o_pll_locked(locked)
  );
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t got %08h expected %08h..%08h", $time, got, lo, hi);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= scs_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic count_rises(input int settle, input int win, output logic [31:0] n);
    logic prev;
    repeat (settle) @(posedge clk);
    n = 32'h0;
    prev = sclk;
    repeat (win) begin
      @(posedge clk);
      #1;
      n = n + {31'h0, sclk === 1'b1 && prev === 1'b0};
      prev = sclk;
    end
  endtask : count_rises
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    logic [31:0] r, a, n;
    logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
    logic [31:0] rv [4] = '{32'h0, 32'h0001_0301, 32'h0, 32'h0};
    int pt [3][4] = '{'{0, 1023, 8192, 2}, '{1, 2, 30, 20}, '{0, 0, 8, 40}};
    int prev;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(ra[i], 1'b0, 32'h0, r);
      check(r, rv[i], rv[i]);
    end
    wr(8'h10, 32'hFFFF_FFFF);
    bus(8'h10, 1'b0, 32'h0, r);
    check(r, 32'h0, 32'h0);
    $display("test registers done");
    count_rises(150, 600, n);
    check(n, 32'd49, 32'd51);
    wr(scs_pkg::SYS_CFG_OFS, 32'h3);
    count_rises(150, 600, n);
    check(n, 32'd99, 32'd101);
    bus(scs_pkg::STATUS_OFS, 1'b0, 32'h0, r);
    check({30'h0, r[31:30]}, 32'h3, 32'h3);
    $display("test wakeup and direct done");
    // Divider is set before the source so no unintended ratio is ever selected
    prev = 12;
    for (int i = 0; i < 3; i++) begin
      wr(scs_pkg::PRESC_OFS, 32'(pt[i][1]));
      wr(scs_pkg::SYS_CFG_OFS, 32'(pt[i][0] * 4 + 2));
      count_rises(2 * (prev + pt[i][2]) + 20, pt[i][2] * pt[i][3], n);
      check(n, 32'(pt[i][3] - 1), 32'(pt[i][3] + 1));
      prev = pt[i][2];
    end
    $display("test prescaler done");
    wr(scs_pkg::PLL_CFG_OFS, 32'h0001_0F00);
    bus(scs_pkg::STATUS_OFS, 1'b0, 32'h0, r);
    check({16'h0, r[15:0]}, {16'h0, scs_pkg::BAND0_MIN}, {16'h0, scs_pkg::BAND0_MAX});
    // Reference chosen so sixteen loop periods match one reference period at this step
    hp[0] = (524288 + int'(r[15:0]) / 2) / int'(r[15:0]);
    prev = 0;
    while (locked !== 1'b1 && prev < 12000) begin
      @(posedge clk);
      prev++;
    end
    check({31'h0, locked}, 32'h1, 32'h1);
    for (int k = 1; k <= 3; k += 2) begin
      wr(scs_pkg::PLL_CFG_OFS, 32'h0000_0F00 | 32'(k << 16));
      count_rises(8 * hp[0], 16 * hp[0], n);
      check(n, 32'(128 / (k + 1) - 2), 32'(128 / (k + 1) + 2));
    end
    bus(scs_pkg::STATUS_OFS, 1'b0, 32'h0, a);
    repeat (hp[0]) @(posedge clk);
    bus(scs_pkg::STATUS_OFS, 1'b0, 32'h0, r);
    check({16'h0, r[15:0]} + 32'h1 - {16'h0, a[15:0]}, 32'h0, 32'h2);
    check({30'h0, r[31:30]}, 32'h2, 32'h2);
    wr(scs_pkg::PLL_CFG_OFS, 32'h0003_0F02);
    repeat (10) @(posedge clk);
    bus(scs_pkg::STATUS_OFS, 1'b0, 32'h0, r);
    check({16'h0, r[15:0]}, {16'h0, scs_pkg::BAND1_MIN}, {16'h0, scs_pkg::BAND1_MAX});
    $display("test loop done");
    give_verdict();
  end
  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
